// ### hw/pwc_map.svh
`ifndef PWC_MAP_SVH
`define PWC_MAP_SVH
`define PWC_OFS_ACTIVE 8'hB1
`define PWC_OFS_SLEEP 8'hB2
`define PWC_OFS_CMP 8'hB3
`define PWC_OFS_CTL 8'hB4
`define PWC_OFS_SEQ 8'hB5
`define PWC_BIT_ACT1 0
`define PWC_BIT_SLP1 0
`define PWC_BIT_SLP3 2
`define PWC_BIT_SLP4 3
`define PWC_BIT_SLP6 5
`define PWC_BIT_FAILACT 14
`define PWC_BIT_HIBON 12
`define PWC_POS_OFFTHR 4
`define PWC_POS_ONTHR 0
`define PWC_POS_CAP 14
`define PWC_BIT_OVPDIS 11
`define PWC_BIT_FLOAT 10
`define PWC_POS_VSEL 0
`define PWC_POS_FACT 14
`define PWC_POS_ENSLOT 10
`define PWC_POS_SDSLOT 6
`define PWC_RST_ACT1 1'b1
`define PWC_RST_SLP 1'b0
`define PWC_RST_FAILACT 1'b0
`define PWC_RST_HIBON 1'b0
`define PWC_RST_OFFTHR 3'h2
`define PWC_RST_ONTHR 3'h5
`define PWC_RST_CAP 2'h0
`define PWC_RST_OVPDIS 1'b0
`define PWC_RST_FLOAT 1'b0
`define PWC_RST_VSEL 7'h0E
`define PWC_RST_FACT 2'h0
`define PWC_RST_ENSLOT 4'h0
`define PWC_RST_SDSLOT 4'h0
`define PWC_THR_BASE_MV 12'hB54
`define PWC_THR_STEP_MV 12'h064
`define PWC_V_BASE_MV 12'h352
`define PWC_V_STEP_MV 12'h019
`define PWC_VSEL_MAX 7'h66
`define PWC_SLOT_OFF 4'h0
`define PWC_SLOT_ACTIVE 4'hF
`endif

// ### hw/pwc_pkg.sv
package pwc_pkg;
   typedef enum logic [1:0] {
      FACT_IGNORE,
      FACT_CONV_OFF,
      FACT_SYS_OFF,
      FACT_RSVD
   } pwc_fact_t;
   typedef struct packed {
      logic fail_action;
      logic hib_on;
      logic [2:0] off_thr;
      logic [2:0] on_thr;
   } pwc_cmp_t;
   typedef struct packed {
      logic [1:0] cap;
      logic ovp_dis;
      logic out_float;
      logic [6:0] vsel;
   } pwc_ctl_t;
   typedef struct packed {
      pwc_fact_t fault_act;
      logic [3:0] en_slot;
      logic [3:0] sd_slot;
   } pwc_seq_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } pwc_req_t;
endpackage

// ### hw/pwc_regs.sv
// How it works
// - active bit: 0 standby, 1 active, default 1
// - sleep bits 0,2,3,5 select LDO mode
// - supply fail: interrupt, shutdown if action set
// - off threshold code maps 2.9V to 3.6V
// - on threshold code maps 2.9V to 3.6V
// - thresholds writable only while key unlocked
// - comparator runs in hibernate only if enabled
// - capacitor range field, code 10 unused
// - overvoltage bit 1 disables protection
// - disabled converter discharged unless float set
// - voltage code 25mV steps from 0.85V
// - fault always interrupts, action field selects response
// - startup slot: 0 off, 1-14 slots, 15 active
// - shutdown slot 0 turns off entering off
// - shutdown slots 1-14 in shutdown sequence
`timescale 1ns/1ps
`include "pwc_map.svh"
module pwc_regs
   import pwc_pkg::*;
(
   input wire logic CLK_I,
   input wire logic ARST_N_I,
   input wire logic SM_RESET_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [15:0] REG_WDATA_I,
   output logic [15:0] REG_RDATA_O,
   input wire logic KEY_UNLOCK_I,
   input wire logic HIBERNATE_I,
   input wire logic SUPPLY_LOW_I,
   input wire logic CONV1_FAULT_I,
   input wire logic [3:0] SEQ_SLOT_I,
   input wire logic SEQ_UP_STEP_I,
   input wire logic SEQ_DOWN_STEP_I,
   input wire logic ENTER_ACTIVE_I,
   input wire logic ENTER_OFF_I,
   output logic CONV1_ACTIVE_O,
   output logic [5:0] CONV_SLEEP_LDO_O,
   output logic SUPPLY_COMP_EN_O,
   output logic [11:0] SUPPLY_OFF_MV_O,
   output logic [11:0] SUPPLY_ON_MV_O,
   output logic [1:0] CONV1_CAP_O,
   output logic CONV1_OVP_EN_O,
   output logic [11:0] CONV1_MV_O,
   output logic CONV1_EN_O,
   output logic CONV1_DISCHARGE_O,
   output logic SUPPLY_FAIL_IRQ_O,
   output logic CONV1_FAULT_IRQ_O,
   output logic HARD_SHUTDOWN_O,
   output logic SYS_SHUTDOWN_O
);

   function automatic logic [11:0] thr_mv(input logic [2:0] code);
      logic [11:0] step;
      step = `PWC_THR_STEP_MV * {9'h000, code};
      return `PWC_THR_BASE_MV + step;
   endfunction
   function automatic logic [11:0] volt_mv(input logic [6:0] code);
      logic [6:0] lim;
      logic [11:0] step;
      lim = (code > `PWC_VSEL_MAX) ? `PWC_VSEL_MAX : code;
      step = `PWC_V_STEP_MV * {5'h00, lim};
      return `PWC_V_BASE_MV + step;
   endfunction

   pwc_req_t req;
   logic conv1_active_sel_r;
   logic conv1_sleep_ldo_r, conv3_sleep_ldo_r;
   logic conv4_sleep_ldo_r, conv6_sleep_ldo_r;
   pwc_cmp_t cmp_r;
   pwc_ctl_t ctl_r;
   pwc_seq_t seq_r;
   logic wr_act, wr_slp, wr_cmp, wr_ctl, wr_seq;
   logic [15:0] rdata_nxt;
   logic low_meta_r, low_sync_r, low_prev_r;
   logic flt_meta_r, flt_sync_r, flt_prev_r;
   logic low_rise, flt_rise;
   logic conv1_en_r, up_hit, down_hit;
   assign req = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I,
                  wdata: REG_WDATA_I};
   assign wr_act = req.wr && (req.addr == `PWC_OFS_ACTIVE);
   assign wr_slp = req.wr && (req.addr == `PWC_OFS_SLEEP);
   assign wr_cmp = req.wr && (req.addr == `PWC_OFS_CMP);
   assign wr_ctl = req.wr && (req.addr == `PWC_OFS_CTL);
   assign wr_seq = req.wr && (req.addr == `PWC_OFS_SEQ);

   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         conv1_active_sel_r <= `PWC_RST_ACT1;
      else if (SM_RESET_I)
         conv1_active_sel_r <= `PWC_RST_ACT1;
      else if (wr_act)
         conv1_active_sel_r <= req.wdata[`PWC_BIT_ACT1];
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         conv1_sleep_ldo_r <= `PWC_RST_SLP;
         conv3_sleep_ldo_r <= `PWC_RST_SLP;
         conv4_sleep_ldo_r <= `PWC_RST_SLP;
         conv6_sleep_ldo_r <= `PWC_RST_SLP;
      end
      else if (SM_RESET_I)
      begin
         conv1_sleep_ldo_r <= `PWC_RST_SLP;
         conv3_sleep_ldo_r <= `PWC_RST_SLP;
         conv4_sleep_ldo_r <= `PWC_RST_SLP;
         conv6_sleep_ldo_r <= `PWC_RST_SLP;
      end
      else if (wr_slp)
      begin
         conv1_sleep_ldo_r <= req.wdata[`PWC_BIT_SLP1];
         conv3_sleep_ldo_r <= req.wdata[`PWC_BIT_SLP3];
         conv4_sleep_ldo_r <= req.wdata[`PWC_BIT_SLP4];
         conv6_sleep_ldo_r <= req.wdata[`PWC_BIT_SLP6];
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         cmp_r.fail_action <= `PWC_RST_FAILACT;
         cmp_r.hib_on <= `PWC_RST_HIBON;
         cmp_r.off_thr <= `PWC_RST_OFFTHR;
         cmp_r.on_thr <= `PWC_RST_ONTHR;
      end
      else if (SM_RESET_I)
      begin
         cmp_r.fail_action <= `PWC_RST_FAILACT;
      end
      else if (wr_cmp)
      begin
         cmp_r.fail_action <= req.wdata[`PWC_BIT_FAILACT];
         cmp_r.hib_on <= req.wdata[`PWC_BIT_HIBON];
         if (KEY_UNLOCK_I)
         begin
            cmp_r.off_thr <= req.wdata[`PWC_POS_OFFTHR +: 3];
            cmp_r.on_thr <= req.wdata[`PWC_POS_ONTHR +: 3];
         end
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         ctl_r.cap <= `PWC_RST_CAP;
         ctl_r.ovp_dis <= `PWC_RST_OVPDIS;
         ctl_r.out_float <= `PWC_RST_FLOAT;
         ctl_r.vsel <= `PWC_RST_VSEL;
      end
      else if (SM_RESET_I)
      begin
         ctl_r.cap <= `PWC_RST_CAP;
         ctl_r.ovp_dis <= `PWC_RST_OVPDIS;
         ctl_r.vsel <= `PWC_RST_VSEL;
      end
      else if (wr_ctl)
      begin
         ctl_r.cap <= req.wdata[`PWC_POS_CAP +: 2];
         ctl_r.ovp_dis <= req.wdata[`PWC_BIT_OVPDIS];
         ctl_r.out_float <= req.wdata[`PWC_BIT_FLOAT];
         ctl_r.vsel <= req.wdata[`PWC_POS_VSEL +: 7];
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         seq_r.fault_act <= pwc_fact_t'(`PWC_RST_FACT);
         seq_r.en_slot <= `PWC_RST_ENSLOT;
         seq_r.sd_slot <= `PWC_RST_SDSLOT;
      end
      else if (SM_RESET_I)
      begin
         seq_r.fault_act <= pwc_fact_t'(`PWC_RST_FACT);
         seq_r.en_slot <= `PWC_RST_ENSLOT;
         seq_r.sd_slot <= `PWC_RST_SDSLOT;
      end
      else if (wr_seq)
      begin
         seq_r.fault_act <= pwc_fact_t'(req.wdata[`PWC_POS_FACT +: 2]);
         seq_r.en_slot <= req.wdata[`PWC_POS_ENSLOT +: 4];
         seq_r.sd_slot <= req.wdata[`PWC_POS_SDSLOT +: 4];
      end
   end

   always_comb
   begin
      rdata_nxt = 16'h0000;
      case (req.addr)
         `PWC_OFS_ACTIVE:
            rdata_nxt[`PWC_BIT_ACT1] = conv1_active_sel_r;
         `PWC_OFS_SLEEP:
         begin
            rdata_nxt[`PWC_BIT_SLP1] = conv1_sleep_ldo_r;
            rdata_nxt[`PWC_BIT_SLP3] = conv3_sleep_ldo_r;
            rdata_nxt[`PWC_BIT_SLP4] = conv4_sleep_ldo_r;
            rdata_nxt[`PWC_BIT_SLP6] = conv6_sleep_ldo_r;
         end
         `PWC_OFS_CMP:
         begin
            rdata_nxt[`PWC_BIT_FAILACT] = cmp_r.fail_action;
            rdata_nxt[`PWC_BIT_HIBON] = cmp_r.hib_on;
            rdata_nxt[`PWC_POS_OFFTHR +: 3] = cmp_r.off_thr;
            rdata_nxt[`PWC_POS_ONTHR +: 3] = cmp_r.on_thr;
         end
         `PWC_OFS_CTL:
         begin
            rdata_nxt[`PWC_POS_CAP +: 2] = ctl_r.cap;
            rdata_nxt[`PWC_BIT_OVPDIS] = ctl_r.ovp_dis;
            rdata_nxt[`PWC_BIT_FLOAT] = ctl_r.out_float;
            rdata_nxt[`PWC_POS_VSEL +: 7] = ctl_r.vsel;
         end
         `PWC_OFS_SEQ:
         begin
            rdata_nxt[`PWC_POS_FACT +: 2] = seq_r.fault_act;
            rdata_nxt[`PWC_POS_ENSLOT +: 4] = seq_r.en_slot;
            rdata_nxt[`PWC_POS_SDSLOT +: 4] = seq_r.sd_slot;
         end
         default: rdata_nxt = 16'h0000;
      endcase
   end
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         REG_RDATA_O <= 16'h0000;
      else if (req.rd)
         REG_RDATA_O <= rdata_nxt;
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         low_meta_r <= 1'b0;
         low_sync_r <= 1'b0;
         low_prev_r <= 1'b0;
         flt_meta_r <= 1'b0;
         flt_sync_r <= 1'b0;
         flt_prev_r <= 1'b0;
      end
      else
      begin
         low_meta_r <= SUPPLY_LOW_I;
         low_sync_r <= low_meta_r;
         low_prev_r <= low_sync_r;
         flt_meta_r <= CONV1_FAULT_I;
         flt_sync_r <= flt_meta_r;
         flt_prev_r <= flt_sync_r;
      end
   end

   assign low_rise = low_sync_r && !low_prev_r;
   assign flt_rise = flt_sync_r && !flt_prev_r;

   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         SUPPLY_FAIL_IRQ_O <= 1'b0;
         HARD_SHUTDOWN_O <= 1'b0;
         CONV1_FAULT_IRQ_O <= 1'b0;
         SYS_SHUTDOWN_O <= 1'b0;
      end
      else
      begin
         SUPPLY_FAIL_IRQ_O <= low_rise;
         HARD_SHUTDOWN_O <= low_rise && cmp_r.fail_action;
         CONV1_FAULT_IRQ_O <= flt_rise;
         SYS_SHUTDOWN_O <= flt_rise &&
            (seq_r.fault_act == FACT_SYS_OFF ||
             seq_r.fault_act == FACT_RSVD);
      end
   end

   assign up_hit = (SEQ_UP_STEP_I && seq_r.en_slot != `PWC_SLOT_OFF &&
                    seq_r.en_slot != `PWC_SLOT_ACTIVE &&
                    SEQ_SLOT_I == seq_r.en_slot) ||
                   (ENTER_ACTIVE_I && seq_r.en_slot == `PWC_SLOT_ACTIVE);
   assign down_hit = (SEQ_DOWN_STEP_I &&
                      seq_r.sd_slot != `PWC_SLOT_OFF &&
                      seq_r.sd_slot != `PWC_SLOT_ACTIVE &&
                      SEQ_SLOT_I == seq_r.sd_slot) ||
                     (ENTER_OFF_I && (seq_r.sd_slot == `PWC_SLOT_OFF ||
                      seq_r.sd_slot == `PWC_SLOT_ACTIVE));
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         conv1_en_r <= 1'b0;
      else if (flt_rise && seq_r.fault_act == FACT_CONV_OFF)
         conv1_en_r <= 1'b0;
      else if (down_hit)
         conv1_en_r <= 1'b0;
      else if (up_hit)
         conv1_en_r <= 1'b1;
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         CONV1_ACTIVE_O <= `PWC_RST_ACT1;
         CONV_SLEEP_LDO_O <= 6'h00;
         SUPPLY_COMP_EN_O <= 1'b1;
         SUPPLY_OFF_MV_O <= 12'h000;
         SUPPLY_ON_MV_O <= 12'h000;
         CONV1_CAP_O <= `PWC_RST_CAP;
         CONV1_OVP_EN_O <= 1'b1;
         CONV1_MV_O <= 12'h000;
         CONV1_EN_O <= 1'b0;
         CONV1_DISCHARGE_O <= 1'b0;
      end
      else
      begin
         CONV1_ACTIVE_O <= conv1_active_sel_r;
         CONV_SLEEP_LDO_O <= {conv6_sleep_ldo_r, 1'b0, conv4_sleep_ldo_r,
                              conv3_sleep_ldo_r, 1'b0, conv1_sleep_ldo_r};
         SUPPLY_COMP_EN_O <= !HIBERNATE_I || cmp_r.hib_on;
         SUPPLY_OFF_MV_O <= thr_mv(cmp_r.off_thr);
         SUPPLY_ON_MV_O <= thr_mv(cmp_r.on_thr);
         CONV1_CAP_O <= ctl_r.cap;
         CONV1_OVP_EN_O <= !ctl_r.ovp_dis;
         CONV1_MV_O <= volt_mv(ctl_r.vsel);
         CONV1_EN_O <= conv1_en_r;
         CONV1_DISCHARGE_O <= !conv1_en_r && !ctl_r.out_float;
      end
   end

endmodule

// ### verification/pwc_regs_assertions.sv
`timescale 1ns/1ps
module pwc_regs_chk
   import pwc_pkg::*;
(
   input wire logic CLK_I,
   input wire logic ARST_N_I,
   input wire logic HIBERNATE_I,
   input wire logic SUPPLY_LOW_I,
   input wire logic CONV1_FAULT_I,
   input wire logic SEQ_UP_STEP_I,
   input wire logic ENTER_ACTIVE_I,
   input wire logic SUPPLY_COMP_EN_O,
   input wire logic [11:0] SUPPLY_OFF_MV_O,
   input wire logic [11:0] CONV1_MV_O,
   input wire logic CONV1_EN_O,
   input wire logic CONV1_DISCHARGE_O,
   input wire logic SUPPLY_FAIL_IRQ_O,
   input wire logic CONV1_FAULT_IRQ_O,
   input wire logic HARD_SHUTDOWN_O,
   input wire logic SYS_SHUTDOWN_O
);
   wire logic go;
   assign go = SEQ_UP_STEP_I | ENTER_ACTIVE_I;
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!ARST_N_I);
   a_supply_irq_time:
      assert property ($rose(SUPPLY_LOW_I) |-> ##[3:5] SUPPLY_FAIL_IRQ_O)
      else $error("supply fail pulse missing");
   a_hard_needs_irq:
      assert property (HARD_SHUTDOWN_O |-> SUPPLY_FAIL_IRQ_O)
      else $error("hard shutdown without interrupt");
   a_fault_irq_time:
      assert property ($rose(CONV1_FAULT_I) |-> ##[3:5] CONV1_FAULT_IRQ_O)
      else $error("fault pulse missing");
   a_sys_needs_irq:
      assert property (SYS_SHUTDOWN_O |-> CONV1_FAULT_IRQ_O)
      else $error("system shutdown without interrupt");
   a_fault_irq_pulse:
      assert property (CONV1_FAULT_IRQ_O |=> !CONV1_FAULT_IRQ_O)
      else $error("fault pulse too long");
   a_comp_awake_on:
      assert property (!HIBERNATE_I [*2] |-> SUPPLY_COMP_EN_O)
      else $error("comparator off while awake");
   a_off_thr_range:
      assert property ($past(ARST_N_I) |-> SUPPLY_OFF_MV_O >= 12'hB54
         && SUPPLY_OFF_MV_O <= 12'hE10 && SUPPLY_OFF_MV_O % 12'h064 == 12'h000)
      else $error("off threshold out of range");
   a_volt_range:
      assert property ($past(ARST_N_I) |-> CONV1_MV_O >= 12'h352
         && CONV1_MV_O <= 12'hD48 && CONV1_MV_O % 12'h019 == 12'h000)
      else $error("converter voltage out of range");
   a_en_no_discharge:
      assert property (CONV1_EN_O [*2] |-> !CONV1_DISCHARGE_O)
      else $error("discharge while enabled");
   a_en_rise_cause:
      assert property ($rose(CONV1_EN_O) |-> $past(go) || $past(go, 2)
         || $past(go, 3))
      else $error("enable rose without strobe");
   c_hard: cover property (HARD_SHUTDOWN_O);
   c_sys: cover property (SYS_SHUTDOWN_O);
   c_en_on: cover property ($rose(CONV1_EN_O));
   c_en_off: cover property ($fell(CONV1_EN_O));
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
   import pwc_pkg::*;
   logic CLK_I, ARST_N_I, SM_RESET_I, REG_WR_I, REG_RD_I, KEY_UNLOCK_I;
   logic HIBERNATE_I, SUPPLY_LOW_I, CONV1_FAULT_I, SEQ_UP_STEP_I;
   logic SEQ_DOWN_STEP_I, ENTER_ACTIVE_I, ENTER_OFF_I;
   logic [7:0] REG_ADDR_I;
   logic [15:0] REG_WDATA_I, REG_RDATA_O;
   logic [3:0] SEQ_SLOT_I;
   logic [5:0] CONV_SLEEP_LDO_O;
   logic [11:0] SUPPLY_OFF_MV_O, SUPPLY_ON_MV_O, CONV1_MV_O;
   logic [1:0] CONV1_CAP_O;
   logic CONV1_ACTIVE_O, SUPPLY_COMP_EN_O, CONV1_OVP_EN_O, CONV1_EN_O;
   logic CONV1_DISCHARGE_O, SUPPLY_FAIL_IRQ_O, CONV1_FAULT_IRQ_O;
   logic HARD_SHUTDOWN_O, SYS_SHUTDOWN_O;
   int error_cnt = 0;
   int n_checks = 0;
   int idx;
   logic [15:0] wd;
   int cnt [4];
   logic [31:0] lfsr_s = 32'h1943;
   logic [15:0] m [5];
   logic [15:0] msk [5] =
      '{16'h0001, 16'h002D, 16'h5077, 16'hCC7F, 16'hFFC0};
   logic [6:0] vc [4] = '{7'h7F, 7'h66, 7'h65, 7'h00};

   pwc_regs u_pwc_regs (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
      .SM_RESET_I(SM_RESET_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
      .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
      .REG_RDATA_O(REG_RDATA_O), .KEY_UNLOCK_I(KEY_UNLOCK_I),
      .HIBERNATE_I(HIBERNATE_I), .SUPPLY_LOW_I(SUPPLY_LOW_I),
      .CONV1_FAULT_I(CONV1_FAULT_I), .SEQ_SLOT_I(SEQ_SLOT_I),
      .SEQ_UP_STEP_I(SEQ_UP_STEP_I), .SEQ_DOWN_STEP_I(SEQ_DOWN_STEP_I),
      .ENTER_ACTIVE_I(ENTER_ACTIVE_I), .ENTER_OFF_I(ENTER_OFF_I),
      .CONV1_ACTIVE_O(CONV1_ACTIVE_O), .CONV_SLEEP_LDO_O(CONV_SLEEP_LDO_O),
      .SUPPLY_COMP_EN_O(SUPPLY_COMP_EN_O), .SUPPLY_OFF_MV_O(SUPPLY_OFF_MV_O),
      .SUPPLY_ON_MV_O(SUPPLY_ON_MV_O), .CONV1_CAP_O(CONV1_CAP_O),
      .CONV1_OVP_EN_O(CONV1_OVP_EN_O), .CONV1_MV_O(CONV1_MV_O),
      .CONV1_EN_O(CONV1_EN_O), .CONV1_DISCHARGE_O(CONV1_DISCHARGE_O),
      .SUPPLY_FAIL_IRQ_O(SUPPLY_FAIL_IRQ_O),
      .CONV1_FAULT_IRQ_O(CONV1_FAULT_IRQ_O),
      .HARD_SHUTDOWN_O(HARD_SHUTDOWN_O), .SYS_SHUTDOWN_O(SYS_SHUTDOWN_O));

   initial
   begin
      CLK_I = 1'b0;
      forever #20 CLK_I = ~CLK_I;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [11:0] thr_mv(input logic [2:0] c);
      return 12'hB54 + 12'h064 * c;
   endfunction
   function automatic logic [11:0] out_mv(input logic [6:0] c);
      return 12'h352 + 12'h019 * ((c > 7'h66) ? 7'h66 : c);
   endfunction

   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic tick();
      @(posedge CLK_I);
      #2;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e,
      input string w);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("FAIL %0t %s got %h exp %h", $time, w, g, e);
      end
   endtask
   // write, model follows unless lost
   task automatic wr(input int i, input logic [15:0] d);
      logic [15:0] k;
      k = (i == 2 && !KEY_UNLOCK_I) ? 16'h5000 : msk[i];
      if (!SM_RESET_I)
         m[i] = (m[i] & ~k) | (d & k);
      REG_WR_I = 1'b1;
      REG_ADDR_I = 8'hB1 + 8'(i);
      REG_WDATA_I = d;
      tick();
      REG_WR_I = 1'b0;
      tick();
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      REG_RD_I = 1'b1;
      REG_ADDR_I = a;
      tick();
      REG_RD_I = 1'b0;
      tick();
      chk(REG_RDATA_O, e, "read");
   endtask
   task automatic outs();
      tick();
      chk(16'(CONV1_ACTIVE_O), 16'(m[0][0]), "active");
      chk(16'(CONV_SLEEP_LDO_O), 16'(m[1][5:0]), "sleep");
      chk(16'(SUPPLY_OFF_MV_O), 16'(thr_mv(m[2][6:4])), "off");
      chk(16'(SUPPLY_ON_MV_O), 16'(thr_mv(m[2][2:0])), "on");
      chk(16'(SUPPLY_COMP_EN_O), 16'(!HIBERNATE_I | m[2][12]), "cmp");
      chk(16'(CONV1_CAP_O), 16'(m[3][15:14]), "cap");
      chk(16'(CONV1_OVP_EN_O), 16'(!m[3][11]), "ovp");
      chk(16'(CONV1_MV_O), 16'(out_mv(m[3][6:0])), "mv");
   endtask
   task automatic enc(input logic e);
      chk(16'({CONV1_EN_O, CONV1_DISCHARGE_O}), 16'({e, !e & !m[3][10]}),
         "enable");
   endtask
   task automatic strobe(input logic [3:0] s, input logic [3:0] slot);
      SEQ_SLOT_I = slot;
      {ENTER_OFF_I, ENTER_ACTIVE_I, SEQ_DOWN_STEP_I, SEQ_UP_STEP_I} = s;
      tick();
      {ENTER_OFF_I, ENTER_ACTIVE_I, SEQ_DOWN_STEP_I, SEQ_UP_STEP_I} = 4'h0;
      repeat (3) tick();
   endtask
   task automatic evt(input logic fault);
      cnt = '{0, 0, 0, 0};
      CONV1_FAULT_I = fault;
      SUPPLY_LOW_I = !fault;
      repeat (10)
      begin
         tick();
         cnt[0] += (SUPPLY_FAIL_IRQ_O !== 1'b0);
         cnt[1] += (HARD_SHUTDOWN_O !== 1'b0);
         cnt[2] += (CONV1_FAULT_IRQ_O !== 1'b0);
         cnt[3] += (SYS_SHUTDOWN_O !== 1'b0);
      end
      CONV1_FAULT_I = 1'b0;
      SUPPLY_LOW_I = 1'b0;
      repeat (4) tick();
   endtask

   initial
   begin
      repeat (20000) @(posedge CLK_I);
      error_cnt++;
      $display("FAIL %0t timeout", $time);
      final_report();
   end

   initial
   begin
      {ARST_N_I, SM_RESET_I, REG_WR_I, REG_RD_I, KEY_UNLOCK_I} = 5'h00;
      {HIBERNATE_I, SUPPLY_LOW_I, CONV1_FAULT_I, SEQ_UP_STEP_I} = 4'h0;
      {SEQ_DOWN_STEP_I, ENTER_ACTIVE_I, ENTER_OFF_I} = 3'h0;
      REG_ADDR_I = 8'h00;
      REG_WDATA_I = 16'h0000;
      SEQ_SLOT_I = 4'h0;
      m = '{16'h0001, 16'h0000, 16'h0025, 16'h000E, 16'h0000};
      repeat (6) @(posedge CLK_I);
      #2;
      ARST_N_I = 1'b1;
      tick();
      for (int i = 0; i < 5; i++)
         rd(8'hB1 + 8'(i), m[i]);
      rd(8'hB0, 16'h0000);
      rd(8'hB6, 16'h0000);
      outs();
      enc(1'b0);
      // random writes with random key and hibernate
      repeat (40)
      begin
         lfsr_s = lfsr(lfsr_s);
         KEY_UNLOCK_I = lfsr_s[0];
         HIBERNATE_I = lfsr_s[1];
         idx = int'(lfsr_s[4:2]) % 5;
         wd = lfsr_s[31:16];
         if (idx == 3 && wd[15:14] == 2'b10)
            wd[14] = 1'b1;
         wr(idx, wd);
         outs();
         rd(8'hB1 + 8'(idx), m[idx]);
         enc(1'b0);
      end
      for (int i = 0; i < 4; i++)
      begin
         wr(3, {9'h000, vc[i]});
         outs();
      end
      // start-up and shutdown slots
      for (int k = 1; k < 15; k++)
      begin
         wr(4, 16'(k << 10 | k << 6));
         strobe(4'h1, 4'(k - 1));
         enc(1'b0);
         strobe(4'h1, 4'(k));
         enc(1'b1);
         strobe(4'h2, 4'(k - 1));
         enc(1'b1);
         strobe(4'h2, 4'(k));
         enc(1'b0);
      end
      wr(4, 16'h3C00);
      strobe(4'h1, 4'h5);
      enc(1'b0);
      strobe(4'h4, 4'h0);
      enc(1'b1);
      strobe(4'h8, 4'h0);
      enc(1'b0);
      wr(4, 16'h0000);
      strobe(4'h4, 4'h0);
      strobe(4'h1, 4'h0);
      enc(1'b0);
      // supply fail action
      for (int a = 0; a < 2; a++)
      begin
         wr(2, 16'(a << 14));
         evt(1'b0);
         chk(16'(cnt[0]), 16'h0001, "supply irq");
         chk(16'(cnt[1]), 16'(a), "hard off");
      end
      // converter fault action codes
      for (int a = 0; a < 4; a++)
      begin
         wr(4, 16'(a << 14 | 1 << 10));
         strobe(4'h1, 4'h1);
         enc(1'b1);
         evt(1'b1);
         chk(16'(cnt[2]), 16'h0001, "fault irq");
         chk(16'(cnt[3]), 16'(a >= 2), "sys off");
         enc(a != 1);
         strobe(4'h8, 4'h0);
      end
      // machine reset, write during it lost
      KEY_UNLOCK_I = 1'b1;
      wr(0, 16'h0000);
      wr(1, 16'h002D);
      wr(2, 16'h5052);
      wr(3, 16'hCC7F);
      wr(4, 16'hFFC0);
      SM_RESET_I = 1'b1;
      wr(1, 16'h002D);
      SM_RESET_I = 1'b0;
      tick();
      m = '{16'h0001, 16'h0000, 16'h1052, 16'h040E, 16'h0000};
      for (int i = 0; i < 5; i++)
         rd(8'hB1 + 8'(i), m[i]);
      outs();
      enc(1'b0);
      final_report();
   end
endmodule

bind pwc_regs pwc_regs_chk u_pwc_regs_chk (.CLK_I(CLK_I),
   .ARST_N_I(ARST_N_I), .HIBERNATE_I(HIBERNATE_I),
   .SUPPLY_LOW_I(SUPPLY_LOW_I), .CONV1_FAULT_I(CONV1_FAULT_I),
   .SEQ_UP_STEP_I(SEQ_UP_STEP_I), .ENTER_ACTIVE_I(ENTER_ACTIVE_I),
   .SUPPLY_COMP_EN_O(SUPPLY_COMP_EN_O), .SUPPLY_OFF_MV_O(SUPPLY_OFF_MV_O),
   .CONV1_MV_O(CONV1_MV_O), .CONV1_EN_O(CONV1_EN_O),
   .CONV1_DISCHARGE_O(CONV1_DISCHARGE_O),
   .SUPPLY_FAIL_IRQ_O(SUPPLY_FAIL_IRQ_O),
   .CONV1_FAULT_IRQ_O(CONV1_FAULT_IRQ_O),
   .HARD_SHUTDOWN_O(HARD_SHUTDOWN_O), .SYS_SHUTDOWN_O(SYS_SHUTDOWN_O));
